//--- logic/ext_pin_irq_unit.sv
// External pin interrupt unit: eight pin channels with mode, flag, enable.
// Assumes port settings are synchronous inputs; pins are synchronised in two flops; one clock domain.
`timescale 1ns/100ps

// Operation
// [R01] Four 8-bit control registers each hold mode, flag and enable for an odd and an even channel.
// [R02] Mode 00 detects nothing, 01 a low level, 10 a falling edge, 11 both edges, polarity applied first.
// [R03] A channel flag sets when its polarity-adjusted input meets the selected mode condition.
// [R04] Flags are never cleared by hardware; software clears them by writing the register.
// [R05] Release and channel request are high while that channel's flag and enable are both one.
// [R06] Channels 0, 1 and 2 request vectors 800c, 8014 and 8018.
// [R07] Channels 3, 4 and 5 request vectors 801c, 8020 and 8024.
// [R08] Channels 6 and 7 request vectors 8034 and 8038.
// [R09] Port bits all 0 or all 1 give normal polarity; select A 0 with the other three 1 inverts.
// [R10] Channels 0 to 3 use port 3 bits 0 to 3.
// [R11] Channels 4 and 5 use port 2 bits 0 and 1.
// [R12] Channels 6 and 7 use port 4 bits 0 and 1.
// [R13] In hold a return edge to the entry level cannot set a flag, so wake channels use both edges; the code blocks it in falling-edge mode only.
// [R14] The release from hold goes to halt on the RC oscillator, and acceptance resumes normal run.
// [R15] Each pin is synchronised by two flops and edges compare current and previous samples.
// [R16] In level mode the flag is set again each cycle the level persists.
module ext_pin_irq_unit
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    // Register port
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // Pins
    input  wire logic [3:0]  i_port3_pin,
    input  wire logic [1:0]  i_port2_pin,
    input  wire logic [1:0]  i_port4_pin,
    // Port configuration
    input  wire logic [3:0]  i_port3_function_select_a,
    input  wire logic [3:0]  i_port3_function_select_b,
    input  wire logic [3:0]  i_port3_output_latch,
    input  wire logic [3:0]  i_port3_direction,
    input  wire logic [1:0]  i_port2_function_select_a,
    input  wire logic [1:0]  i_port2_function_select_b,
    input  wire logic [1:0]  i_port2_output_latch,
    input  wire logic [1:0]  i_port2_direction,
    input  wire logic [1:0]  i_port4_function_select_a,
    input  wire logic [1:0]  i_port4_function_select_b,
    input  wire logic [1:0]  i_port4_output_latch,
    input  wire logic [1:0]  i_port4_direction,
    // Low-power state
    input  wire logic        i_hold_active,
    input  wire logic        i_irq_accept,
    // Requests and release
    output logic      [7:0]  o_ch_request,
    output logic      [15:0] o_vector,
    output logic             o_hold_release,
    output logic             o_halt_on_rc,
    output logic             o_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CH-1:0]   sync1;
        logic [NUM_CH-1:0]   sync2;
        logic [NUM_CH-1:0]   prev;
        logic [NUM_CH-1:0]   entry_level;
        logic                hold_seen;
        logic [NUM_CH*2-1:0] mode;
        logic [NUM_CH-1:0]   flag;
        logic [NUM_CH-1:0]   enable;
        logic [NUM_CH-1:0]   status;
        logic [NUM_CH-1:0]   mask;
        logic [7:0]          rdata;
        logic [NUM_CH-1:0]   request;
        logic [15:0]         vector;
        logic                release_out;
        logic                halt_rc;
        logic                irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [NUM_CH-1:0] pin_raw;
    logic [NUM_CH-1:0] fsa;
    logic [NUM_CH-1:0] fsb;
    logic [NUM_CH-1:0] lat;
    logic [NUM_CH-1:0] ddr;
    logic [NUM_CH-1:0] invert;
    logic [NUM_CH-1:0] hit;
    logic [NUM_CH-1:0] ctrl_wr;
    logic [NUM_CH-1:0] req_now;

    // ------------------------------------------------------------
    // Pin and polarity selection
    // ------------------------------------------------------------
    assign pin_raw = {i_port4_pin, i_port2_pin, i_port3_pin}; // R10 R11 R12
    assign fsa     = {i_port4_function_select_a, i_port2_function_select_a, i_port3_function_select_a};
    assign fsb     = {i_port4_function_select_b, i_port2_function_select_b, i_port3_function_select_b};
    assign lat     = {i_port4_output_latch, i_port2_output_latch, i_port3_output_latch};
    assign ddr     = {i_port4_direction, i_port2_direction, i_port3_direction};

    // ------------------------------------------------------------
    // Per-channel detection
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic cur;
            logic old;
            logic blocked;
            // Polarity applied before any detection
            assign invert[g]  = ~fsa[g] & fsb[g] & lat[g] & ddr[g]; // R09
            assign cur        = s_q.sync2[g] ^ invert[g];
            assign old        = s_q.prev[g] ^ invert[g];
            // Returning to entry level in hold does not count for a falling edge
            assign blocked    = i_hold_active & s_q.hold_seen & (cur == s_q.entry_level[g]); // R13

            always_comb
            begin
                case (detect_mode_t'(s_q.mode[2*g +: 2])) // R02
                    MODE_OFF:   hit[g] = 1'b0;
                    MODE_LEVEL: hit[g] = ~cur; // R16
                    MODE_EDGE:  hit[g] = old & ~cur & ~blocked; // R15
                    MODE_BOTH:  hit[g] = (old ^ cur);
                    default:    hit[g] = 1'b0;
                endcase
            end

            assign ctrl_wr[g] = i_wr & (i_addr == ADDR_CTRL_CH0_CH1 + 16'(g / 2));
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d       = s_q;

        // ----------------------------------------------------------
        // Synchronisers and hold entry
        // ----------------------------------------------------------
        s_d.sync1 = pin_raw;
        s_d.sync2 = s_q.sync1; // R15
        s_d.prev  = s_q.sync2;
        s_d.hold_seen = i_hold_active;
        // Entry level after polarity, taken in the first hold cycle
        if (i_hold_active && !s_q.hold_seen)
        begin
            s_d.entry_level = s_q.sync2 ^ invert;
        end

        // ----------------------------------------------------------
        // Control register writes
        // ----------------------------------------------------------
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (ctrl_wr[c])
            begin
                if (c % 2 == 1)
                begin
                    s_d.mode[2*c +: 2] = i_wdata[ODD_MODE_LSB +: 2]; // R01
                    s_d.flag[c]        = i_wdata[ODD_FLAG_BIT]; // R04
                    s_d.enable[c]      = i_wdata[ODD_EN_BIT];
                end
                else
                begin
                    s_d.mode[2*c +: 2] = i_wdata[EVEN_MODE_LSB +: 2];
                    s_d.flag[c]        = i_wdata[EVEN_FLAG_BIT];
                    s_d.enable[c]      = i_wdata[EVEN_EN_BIT];
                end
            end
        end

        // ----------------------------------------------------------
        // Source flags and status
        // ----------------------------------------------------------
        for (int c = 0; c < NUM_CH; c++)
        begin
            // Set wins over a software clear
            if (hit[c])
            begin
                s_d.flag[c]   = 1'b1; // R03
                s_d.status[c] = 1'b1;
            end
            // Status bits clear by writing a one
            else if (i_wr && i_addr == ADDR_IRQ_STATUS && i_wdata[c])
            begin
                s_d.status[c] = 1'b0;
            end
        end
        req_now = s_d.flag & s_d.enable; // R05

        // ----------------------------------------------------------
        // Interrupt mask
        // ----------------------------------------------------------
        if (i_wr && i_addr == ADDR_IRQ_MASK)
        begin
            s_d.mask = i_wdata;
        end

        // ----------------------------------------------------------
        // Register read, data stands one cycle
        // ----------------------------------------------------------
        s_d.rdata = UNMAPPED_READ;
        if (i_rd)
        begin
            case (i_addr)
                ADDR_CTRL_CH0_CH1,
                ADDR_CTRL_CH2_CH3,
                ADDR_CTRL_CH4_CH5,
                ADDR_CTRL_CH6_CH7:
                begin
                    for (int p = 0; p < 4; p++)
                    begin
                        if (i_addr == ADDR_CTRL_CH0_CH1 + 16'(p))
                        begin
                            s_d.rdata = {s_q.mode[4*p+2 +: 2], s_q.flag[2*p+1], s_q.enable[2*p+1],
                                         s_q.mode[4*p +: 2], s_q.flag[2*p], s_q.enable[2*p]};
                        end
                    end
                end
                ADDR_IRQ_STATUS: s_d.rdata = s_q.status;
                ADDR_IRQ_MASK:   s_d.rdata = s_q.mask;
                default:         s_d.rdata = UNMAPPED_READ;
            endcase
        end

        // ----------------------------------------------------------
        // Requests, priority to the lowest channel
        // ----------------------------------------------------------
        s_d.request     = req_now;
        s_d.release_out = |req_now; // R05
        s_d.vector      = VEC_NONE;
        for (int v = NUM_CH - 1; v >= 0; v--)
        begin
            if (req_now[v])
            begin
                case (v)
                    0:       s_d.vector = VEC_CH0; // R06
                    1:       s_d.vector = VEC_CH1;
                    2:       s_d.vector = VEC_CH2;
                    3:       s_d.vector = VEC_CH3; // R07
                    4:       s_d.vector = VEC_CH4;
                    5:       s_d.vector = VEC_CH5;
                    6:       s_d.vector = VEC_CH6; // R08
                    default: s_d.vector = VEC_CH7;
                endcase
            end
        end

        // ----------------------------------------------------------
        // Hold release leads to halt on RC until acceptance
        // ----------------------------------------------------------
        if (i_hold_active && |req_now)
        begin
            s_d.halt_rc = 1'b1; // R14
        end
        else if (i_irq_accept)
        begin
            s_d.halt_rc = 1'b0;
        end

        // ----------------------------------------------------------
        // Level interrupt
        // ----------------------------------------------------------
        s_d.irq = |(s_d.status & s_d.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            s_q        <= '0;
            s_q.mode   <= {(NUM_CH / 2){CTRL_RESET[ODD_MODE_LSB +: 2], CTRL_RESET[EVEN_MODE_LSB +: 2]}};
            s_q.flag   <= {(NUM_CH / 2){CTRL_RESET[ODD_FLAG_BIT], CTRL_RESET[EVEN_FLAG_BIT]}};
            s_q.enable <= {(NUM_CH / 2){CTRL_RESET[ODD_EN_BIT], CTRL_RESET[EVEN_EN_BIT]}};
            s_q.mask   <= MASK_RESET;
            s_q.vector <= VEC_NONE;
            // Pin samples keep moving so no false edge follows reset
            s_q.sync1  <= s_d.sync1;
            s_q.sync2  <= s_d.sync2;
            s_q.prev   <= s_d.prev;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_rdata        = s_q.rdata;
    assign o_ch_request   = s_q.request;
    assign o_vector       = s_q.vector;
    assign o_hold_release = s_q.release_out;
    assign o_halt_on_rc   = s_q.halt_rc;
    assign o_irq          = s_q.irq;

endmodule

//--- logic/ext_irq_pkg.sv
// External pin interrupt unit: register map, field layout, vectors.
// Assumes an 8-bit register port at byte offsets and one 200 MHz clock.
package ext_irq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_CTRL_CH0_CH1 = 16'h7fd8;
    localparam logic [15:0] ADDR_CTRL_CH2_CH3 = 16'h7fd9;
    localparam logic [15:0] ADDR_CTRL_CH4_CH5 = 16'h7fda;
    localparam logic [15:0] ADDR_CTRL_CH6_CH7 = 16'h7fdb;
    localparam logic [15:0] ADDR_IRQ_STATUS   = 16'h7fdc;
    localparam logic [15:0] ADDR_IRQ_MASK     = 16'h7fdd;
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [7:0]  MASK_RESET        = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

    // ------------------------------------------------------------
    // Field layout inside a control register
    // ------------------------------------------------------------
    localparam int ODD_MODE_LSB  = 6;
    localparam int ODD_FLAG_BIT  = 5;
    localparam int ODD_EN_BIT    = 4;
    localparam int EVEN_MODE_LSB = 2;
    localparam int EVEN_FLAG_BIT = 1;
    localparam int EVEN_EN_BIT   = 0;
    localparam int NUM_CH        = 8;

    typedef enum logic [1:0]
    {
        MODE_OFF   = 2'b00,
        MODE_LEVEL = 2'b01,
        MODE_EDGE  = 2'b10,
        MODE_BOTH  = 2'b11
    } detect_mode_t;

    // ------------------------------------------------------------
    // Request vectors per channel
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_CH0 = 16'h800c;
    localparam logic [15:0] VEC_CH1 = 16'h8014;
    localparam logic [15:0] VEC_CH2 = 16'h8018;
    localparam logic [15:0] VEC_CH3 = 16'h801c;
    localparam logic [15:0] VEC_CH4 = 16'h8020;
    localparam logic [15:0] VEC_CH5 = 16'h8024;
    localparam logic [15:0] VEC_CH6 = 16'h8034;
    localparam logic [15:0] VEC_CH7 = 16'h8038;
    localparam logic [15:0] VEC_NONE = 16'h0000;

endpackage

//--- dv/ext_irq_properties.sv
// Port checker for the pin interrupt unit.
// Bound to the unit from the bench top file; one clock domain.
`timescale 1ns/100ps
module ext_irq_properties
    import ext_irq_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  o_rdata,
    input  wire logic        i_hold_active,
    input  wire logic        i_irq_accept,
    input  wire logic [7:0]  o_ch_request,
    input  wire logic [15:0] o_vector,
    input  wire logic        o_hold_release,
    input  wire logic        o_halt_on_rc
);
    // ----
    // Properties
    // ----
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);
    sequence s_en0_off;
        i_wr && i_addr == ADDR_CTRL_CH0_CH1 && !i_wdata[EVEN_EN_BIT];
    endsequence
    sequence s_bad_rd;
        i_rd && (i_addr < ADDR_CTRL_CH0_CH1 || i_addr > ADDR_IRQ_MASK);
    endsequence
    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    a_unmapped_read: assert property (s_bad_rd |=> o_rdata == UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_release_any: assert property (o_hold_release == |o_ch_request)
        else $error("release differs from requests");
    a_enable_off: assert property (s_en0_off |=> !o_ch_request[0])
        else $error("request with enable off");
    a_vector_none: assert property (o_ch_request == 8'h00 |-> o_vector == VEC_NONE)
        else $error("vector without request");
    a_vector_ch0: assert property (o_ch_request[0] |-> o_vector == VEC_CH0)
        else $error("vector of channel 0 wrong");
    a_vector_ch3: assert property (o_ch_request == 8'h08 |-> o_vector == VEC_CH3)
        else $error("vector of channel 3 wrong");
    a_vector_ch7: assert property (o_ch_request == 8'h80 |-> o_vector == VEC_CH7)
        else $error("vector of channel 7 wrong");
    a_request_sticky: assert property ($fell(o_hold_release) |-> $past(i_wr))
        else $error("request dropped without write");
    a_halt_set: assert property ($rose(o_halt_on_rc) |-> $past(i_hold_active) && o_hold_release)
        else $error("halt set outside hold release");
    a_halt_clear: assert property (i_irq_accept && !i_hold_active |=> !o_halt_on_rc)
        else $error("halt kept after accept");
endmodule

//--- dv/ext_pin_driver_model.sv
// Far-side pin driver for the eight interrupt channels.
// Pin levels follow the bench command one edge later.
`timescale 1ns/100ps
module ext_pin_driver_model
(
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_level,
    output logic      [3:0] o_port3_pin,
    output logic      [1:0] o_port2_pin,
    output logic      [1:0] o_port4_pin
);
    // ----
    // Pin drive
    // ----
    always @(posedge i_mclk)
    begin
        o_port3_pin <= i_level[3:0];
        o_port2_pin <= i_level[5:4];
        o_port4_pin <= i_level[7:6];
    end
endmodule

//--- dv/ext_pin_irq_unit_tb.sv
// Self-checking bench for the pin interrupt unit.
// Drives registers, pins, port setup and hold; checker bound below.
`timescale 1ns/100ps
module ext_pin_irq_unit_tb
    import ext_irq_pkg::*;
;
    logic        i_mclk = 1'b0;
    logic        i_nrst = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_hold_active = 1'b0;
    logic        i_irq_accept = 1'b0;
    logic [7:0]  lvl = 8'hff;
    logic [7:0]  fsa = 8'h00;
    logic [7:0]  fsb = 8'h00;
    logic [7:0]  lat = 8'h00;
    logic [7:0]  ddr = 8'h00;
    logic [7:0]  o_rdata;
    logic [7:0]  o_ch_request;
    logic [15:0] o_vector;
    logic        o_hold_release;
    logic        o_halt_on_rc;
    logic        o_irq;
    logic [3:0]  i_port3_pin;
    logic [1:0]  i_port2_pin;
    logic [1:0]  i_port4_pin;
    int          error_cnt = 0;
    int          compares = 0;
    always #2.5 i_mclk = ~i_mclk;
    ext_pin_driver_model ext_pin_driver_model_inst (.i_mclk, .i_level(lvl), .o_port3_pin(i_port3_pin),
        .o_port2_pin(i_port2_pin), .o_port4_pin(i_port4_pin));
    ext_pin_irq_unit ext_pin_irq_unit_inst (.i_mclk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_port3_pin, .i_port2_pin, .i_port4_pin, .i_port3_function_select_a(fsa[3:0]),
        .i_port3_function_select_b(fsb[3:0]), .i_port3_output_latch(lat[3:0]), .i_port3_direction(ddr[3:0]),
        .i_port2_function_select_a(fsa[5:4]), .i_port2_function_select_b(fsb[5:4]),
        .i_port2_output_latch(lat[5:4]), .i_port2_direction(ddr[5:4]), .i_port4_function_select_a(fsa[7:6]),
        .i_port4_function_select_b(fsb[7:6]), .i_port4_output_latch(lat[7:6]), .i_port4_direction(ddr[7:6]),
        .i_hold_active, .i_irq_accept, .o_ch_request, .o_vector, .o_hold_release, .o_halt_on_rc, .o_irq);
    // ----
    // Tasks
    // ----
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic set_lvl(input logic [7:0] l);
        @(posedge i_mclk);
        lvl <= l;
    endtask
    // Inverted, or a random one of the two normal settings
    task automatic set_pol(input logic inv);
        logic n;
        n = 1'($urandom);
        @(posedge i_mclk);
        fsa <= inv ? 8'h00 : {8{n}};
        fsb <= {8{inv | n}};
        lat <= {8{inv | n}};
        ddr <= {8{inv | n}};
        lvl <= {8{~inv}};
    endtask
    function automatic logic [15:0] vec_of(input int ch);
        logic [15:0] t [8];
        t = '{VEC_CH0, VEC_CH1, VEC_CH2, VEC_CH3, VEC_CH4, VEC_CH5, VEC_CH6, VEC_CH7};
        return t[ch];
    endfunction
    task automatic finish_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----
    // Sequence
    // ----
    initial
    begin
        #100000;
        error_cnt++;
        finish_test();
    end
    initial
    begin
        logic [7:0]   d;
        logic [7:0]   v;
        logic [15:0]  a;
        logic [15:0]  e;
        detect_mode_t m;
        logic         inv;
        void'($urandom(32'h3bcd));
        repeat (20) @(posedge i_mclk);
        i_nrst <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rd_reg(ADDR_CTRL_CH0_CH1 + 16'(i), d);
            chk("reset", 16'(d), 16'((i == 6) ? UNMAPPED_READ : CTRL_RESET));
        end
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom) & 8'hdd;
            wr_reg(ADDR_CTRL_CH0_CH1 + 16'(i), v);
            rd_reg(ADDR_CTRL_CH0_CH1 + 16'(i), d);
            chk("ctrl rw", 16'(d), 16'(v));
            wr_reg(ADDR_CTRL_CH0_CH1 + 16'(i), 8'h00);
        end
        for (int ch = 0; ch < 8; ch++)
            for (int k = 0; k < 8; k++)
            begin
                m = detect_mode_t'(k / 2);
                inv = k[0];
                set_pol(inv);
                cyc(6);
                v = ch[0] ? {m, 2'b01, 4'h0} : {4'h0, m, 2'b01};
                a = ADDR_CTRL_CH0_CH1 + 16'(ch / 2);
                e = 16'(1 << ch);
                wr_reg(a, v);
                set_lvl({8{~inv}} ^ 8'(1 << ch));
                cyc(5);
                chk("hit", 16'(o_ch_request), (m != MODE_OFF) ? e : 16'h0000);
                chk("vector", o_vector, (m != MODE_OFF) ? vec_of(ch) : VEC_NONE);
                rd_reg(a, d);
                chk("flag", 16'(d), 16'(v | ((m == MODE_OFF) ? 8'h00 : ch[0] ? 8'h20 : 8'h02)));
                wr_reg(a, v);
                cyc(1);
                chk("level", 16'(o_ch_request), (m == MODE_LEVEL) ? e : 16'h0000);
                set_lvl({8{~inv}});
                cyc(5);
                chk("sticky", 16'(o_ch_request), (m == MODE_LEVEL || m == MODE_BOTH) ? e : 16'h0000);
                wr_reg(a, 8'h00);
                cyc(2);
                chk("cleared", 16'(o_ch_request), 16'h0000);
            end
        wr_reg(ADDR_IRQ_STATUS, 8'hff);
        set_pol(1'b0);
        wr_reg(ADDR_CTRL_CH2_CH3, 8'h09);
        set_lvl(8'hfb);
        cyc(5);
        rd_reg(ADDR_IRQ_STATUS, d);
        chk("status", 16'(d), 16'h0004);
        chk("masked", 16'(o_irq), 16'h0000);
        wr_reg(ADDR_IRQ_MASK, 8'h04);
        cyc(1);
        chk("irq", 16'(o_irq), 16'h0001);
        wr_reg(ADDR_IRQ_STATUS, 8'h04);
        cyc(1);
        chk("irq clr", 16'(o_irq), 16'h0000);
        wr_reg(ADDR_CTRL_CH2_CH3, 8'h00);
        set_lvl(8'hfe);
        cyc(5);
        wr_reg(ADDR_CTRL_CH0_CH1, 8'h09);
        i_hold_active <= 1'b1;
        set_lvl(8'hff);
        cyc(5);
        set_lvl(8'hfe);
        cyc(5);
        chk("hold edge", 16'(o_ch_request), 16'h0000);
        wr_reg(ADDR_CTRL_CH0_CH1, 8'h0d);
        set_lvl(8'hff);
        cyc(5);
        chk("wake", 16'(o_hold_release), 16'h0001);
        chk("halt", 16'(o_halt_on_rc), 16'h0001);
        @(posedge i_mclk);
        i_hold_active <= 1'b0;
        i_irq_accept <= 1'b1;
        @(posedge i_mclk);
        i_irq_accept <= 1'b0;
        cyc(1);
        chk("resume", 16'(o_halt_on_rc), 16'h0000);
        finish_test();
    end
endmodule
bind ext_pin_irq_unit ext_irq_properties ext_irq_properties_inst (.i_mclk, .i_nrst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_hold_active, .i_irq_accept, .o_ch_request, .o_vector, .o_hold_release, .o_halt_on_rc);
